//--- include/emst_pkg.sv
package emst_pkg;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] EMST_OFS_TIMING = 8'h84;
    localparam logic [7:0] EMST_OFS_CONFIG = 8'h88;
    localparam logic [7:0] EMST_OFS_PAGE   = 8'h8c;
    localparam logic [7:0] EMST_OFS_PTR0   = 8'h90;
    localparam logic [7:0] EMST_OFS_PTR1   = 8'h94;
    localparam logic [7:0] EMST_OFS_STATUS = 8'h98;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] EMST_RST_TIMING = 8'hff;
    localparam logic [7:0] EMST_RST_CONFIG = 8'h03;
    localparam logic [7:0] EMST_RST_BYTE   = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int EMST_SETUP_MSB = 7;
    localparam int EMST_SETUP_LSB = 6;
    localparam int EMST_WIDTH_MSB = 5;
    localparam int EMST_WIDTH_LSB = 2;
    localparam int EMST_HOLD_MSB  = 1;
    localparam int EMST_HOLD_LSB  = 0;
    localparam int EMST_MODE_MSB  = 4;
    localparam int EMST_MODE_LSB  = 2;
    localparam int EMST_ALE_MSB   = 1;
    localparam int EMST_ALE_LSB   = 0;

    // ----------------------------------------
    // Cycle counts
    // ----------------------------------------
    localparam logic [4:0] EMST_TAIL_CYC = 5'h04;

    // ----------------------------------------
    // Access sequencer states
    // ----------------------------------------
    typedef enum logic [6:0] {
        EMST_IDLE   = 7'h01,
        EMST_ALE_HI = 7'h02,
        EMST_ALE_LO = 7'h04,
        EMST_SETUP  = 7'h08,
        EMST_STROBE = 7'h10,
        EMST_HOLD   = 7'h20,
        EMST_TAIL   = 7'h40
    } emst_state_t;

endpackage : emst_pkg

//--- hw/emst_phase_timer.sv
`timescale 1ns/1ps
module emst_phase_timer #(
    parameter int W = 5
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              expired
);
    import emst_pkg::*;

    logic [W-1:0] cnt_ff;

    // Loads the remaining cycles minus one; expired marks the last cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign expired = (cnt_ff == '0);

endmodule : emst_phase_timer

//--- hw/emst_mode_dec.sv
`timescale 1ns/1ps
module emst_mode_dec (
    input  wire logic [2:0] mode,
    input  wire logic       wide,
    output logic            ext_en,
    output logic            muxed,
    output logic            drive_hi
);
    import emst_pkg::*;

    // Top bit selects the bus style, low bits the memory map
    assign ext_en   = (mode[1:0] != 2'h0);
    assign muxed    = ~mode[2];
    // Wide moves always drive all sixteen address lines
    assign drive_hi = wide | (mode[1:0] == 2'h2);

endmodule : emst_mode_dec

//--- hw/emst_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Address stands stable for setup-field cycles before any strobe.
// - Read or write strobe lasts width field plus one cycles.
// - Address stays valid hold-field cycles after the strobe ends.
// - Timing control register sits at 0x84, every bit read/write.
// - Modes 101, 110, 111 run wide moves non-multiplexed, no latch.
// - Modes 101, 111 run byte moves non-multiplexed, upper byte undriven.
// - Mode 110 runs byte moves non-multiplexed, upper byte from page.
// - Modes 001, 010, 011 run wide moves multiplexed with latch pulse.
// - Modes 001, 011 run byte moves multiplexed, upper byte undriven.
// - Mode 010 runs byte moves multiplexed, upper byte from page.
// - Byte moves take low address from selected pointer register.
// - Multiplexed writes show low address first, then write data.
// - After reset all timing settings are at maximum, all ones.
// - Mux-select bit clear gives multiplexed bus, set non-multiplexed.
// - Each off-chip move adds four cycles to programmed phases.
// - Latch pulse high and low each last latch field plus one.
module emst_ctrl (
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM register slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // External move requests from the core
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic        req_wide,
    input  wire logic        req_ptr_sel,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    output logic             resp_valid,
    output logic [7:0]       resp_rdata,
    // External memory pins
    output logic [7:0]       addr_hi_o,
    output logic             addr_hi_oe_n,
    output logic [7:0]       addr_lo_o,
    output logic [7:0]       data_o,
    input  wire logic [7:0]  data_i,
    output logic             data_oe_n,
    output logic             ale_o,
    output logic             rd_n_o,
    output logic             wr_n_o
);
    import emst_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]  ext_mem_timing_ctrl_ff;
    logic [7:0]  ext_mem_config_reg_ff;
    logic [7:0]  upper_page_reg_ff;
    logic [7:0]  pointer_reg_zero_ff;
    logic [7:0]  pointer_reg_one_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;

    emst_state_t state_ff;
    emst_state_t nxt_state;

    logic [15:0] acc_addr_ff;
    logic [7:0]  acc_wdata_ff;
    logic        acc_write_ff;
    logic [7:0]  resp_rdata_ff;
    logic        resp_valid_ff;

    logic [7:0]  addr_hi_ff;
    logic        addr_hi_oe_n_ff;
    logic [7:0]  addr_lo_ff;
    logic [7:0]  data_ff;
    logic        data_oe_n_ff;
    logic        ale_ff;
    logic        rd_n_ff;
    logic        wr_n_ff;

    logic [1:0]  setup_sel;
    logic [3:0]  width_sel;
    logic [1:0]  hold_sel;
    logic [2:0]  mode_sel;
    logic [1:0]  ale_sel;
    logic        ext_en;
    logic        muxed;
    logic        drive_hi;
    logic        tmr_load;
    logic [4:0]  tmr_val;
    logic        tmr_done;
    logic        start;
    logic [15:0] eff_addr;
    logic        bus_wr;
    logic        bus_rd;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign setup_sel = ext_mem_timing_ctrl_ff[EMST_SETUP_MSB:EMST_SETUP_LSB];
    assign width_sel = ext_mem_timing_ctrl_ff[EMST_WIDTH_MSB:EMST_WIDTH_LSB];
    assign hold_sel  = ext_mem_timing_ctrl_ff[EMST_HOLD_MSB:EMST_HOLD_LSB];
    assign mode_sel  = ext_mem_config_reg_ff[EMST_MODE_MSB:EMST_MODE_LSB];
    assign ale_sel   = ext_mem_config_reg_ff[EMST_ALE_MSB:EMST_ALE_LSB];

    // ----------------------------------------
    // Bus slave: one wait state on every access
    // ----------------------------------------
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign bus_wr = avs_write & ack_ff;
    assign bus_rd = avs_read & ~ack_ff;
    assign avs_readdata = rdata_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_rd) begin
            if (hit(avs_address, EMST_OFS_TIMING)) begin
                rdata_ff <= {24'h00_0000, ext_mem_timing_ctrl_ff};
            end else if (hit(avs_address, EMST_OFS_CONFIG)) begin
                rdata_ff <= {24'h00_0000, ext_mem_config_reg_ff};
            end else if (hit(avs_address, EMST_OFS_PAGE)) begin
                rdata_ff <= {24'h00_0000, upper_page_reg_ff};
            end else if (hit(avs_address, EMST_OFS_PTR0)) begin
                rdata_ff <= {24'h00_0000, pointer_reg_zero_ff};
            end else if (hit(avs_address, EMST_OFS_PTR1)) begin
                rdata_ff <= {24'h00_0000, pointer_reg_one_ff};
            end else if (hit(avs_address, EMST_OFS_STATUS)) begin
                rdata_ff <= {23'h0, state_ff != EMST_IDLE,
                             resp_rdata_ff};
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end

    // Settings can change mid-access; each phase reads them when its timer loads
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_mem_timing_ctrl_ff <= EMST_RST_TIMING;
            ext_mem_config_reg_ff  <= EMST_RST_CONFIG;
            upper_page_reg_ff      <= EMST_RST_BYTE;
            pointer_reg_zero_ff    <= EMST_RST_BYTE;
            pointer_reg_one_ff     <= EMST_RST_BYTE;
        end else if (bus_wr) begin
            if (hit(avs_address, EMST_OFS_TIMING)) begin
                ext_mem_timing_ctrl_ff <= avs_writedata[7:0];
            end else if (hit(avs_address, EMST_OFS_CONFIG)) begin
                ext_mem_config_reg_ff <= avs_writedata[7:0];
            end else if (hit(avs_address, EMST_OFS_PAGE)) begin
                upper_page_reg_ff <= avs_writedata[7:0];
            end else if (hit(avs_address, EMST_OFS_PTR0)) begin
                pointer_reg_zero_ff <= avs_writedata[7:0];
            end else if (hit(avs_address, EMST_OFS_PTR1)) begin
                pointer_reg_one_ff <= avs_writedata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Mode decode and phase timer
    // ----------------------------------------
    emst_mode_dec u_dec (
        .mode     (mode_sel),
        .wide     (req_wide),
        .ext_en   (ext_en),
        .muxed    (muxed),
        .drive_hi (drive_hi)
    );

    emst_phase_timer #(
        .W (5)
    ) u_tmr (
        .clk      (clk),
        .rst      (rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expired  (tmr_done)
    );

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    assign req_ready = (state_ff == EMST_IDLE);
    assign start     = req_valid & req_ready;

    // Byte moves: page supplies upper byte, pointer the lower
    assign eff_addr = req_wide ? req_addr :
        {upper_page_reg_ff,
         req_ptr_sel ? pointer_reg_one_ff
                     : pointer_reg_zero_ff};

    always_comb begin
        nxt_state = state_ff;
        tmr_load  = 1'b0;
        tmr_val   = 5'h00;
        case (state_ff)
            EMST_IDLE: begin
                if (start && ext_en) begin
                    tmr_load = 1'b1;
                    if (muxed) begin
                        nxt_state = EMST_ALE_HI;
                        tmr_val   = {3'h0, ale_sel};
                    end else if (setup_sel != 2'h0) begin
                        nxt_state = EMST_SETUP;
                        tmr_val   = {3'h0, setup_sel - 2'h1};
                    end else begin
                        nxt_state = EMST_STROBE;
                        tmr_val   = {1'b0, width_sel};
                    end
                end
            end
            EMST_ALE_HI: begin
                if (tmr_done) begin
                    nxt_state = EMST_ALE_LO;
                    tmr_load  = 1'b1;
                    tmr_val   = {3'h0, ale_sel};
                end
            end
            EMST_ALE_LO: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (setup_sel != 2'h0) begin
                        nxt_state = EMST_SETUP;
                        tmr_val   = {3'h0, setup_sel - 2'h1};
                    end else begin
                        nxt_state = EMST_STROBE;
                        tmr_val   = {1'b0, width_sel};
                    end
                end
            end
            EMST_SETUP: begin
                if (tmr_done) begin
                    nxt_state = EMST_STROBE;
                    tmr_load  = 1'b1;
                    tmr_val   = {1'b0, width_sel};
                end
            end
            EMST_STROBE: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (hold_sel != 2'h0) begin
                        nxt_state = EMST_HOLD;
                        tmr_val   = {3'h0, hold_sel - 2'h1};
                    end else begin
                        nxt_state = EMST_TAIL;
                        tmr_val   = EMST_TAIL_CYC - 5'h01;
                    end
                end
            end
            EMST_HOLD: begin
                if (tmr_done) begin
                    nxt_state = EMST_TAIL;
                    tmr_load  = 1'b1;
                    tmr_val   = EMST_TAIL_CYC - 5'h01;
                end
            end
            EMST_TAIL: begin
                if (tmr_done) begin
                    nxt_state = EMST_IDLE;
                end
            end
            default: begin
                nxt_state = EMST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= EMST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Request is captured once so the pins cannot move mid-access
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_addr_ff  <= 16'h0000;
            acc_wdata_ff <= 8'h00;
            acc_write_ff <= 1'b0;
        end else if (start) begin
            acc_addr_ff  <= eff_addr;
            acc_wdata_ff <= req_wdata;
            acc_write_ff <= req_write;
        end
    end

    // Read data is sampled in the last strobe cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_rdata_ff <= 8'h00;
        end else if (state_ff == EMST_STROBE && tmr_done &&
                     !acc_write_ff) begin
            resp_rdata_ff <= data_i;
        end else if (start && !ext_en) begin
            resp_rdata_ff <= 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            resp_valid_ff <= 1'b0;
        end else begin
            resp_valid_ff <= (state_ff == EMST_TAIL && tmr_done) |
                             (start && !ext_en);
        end
    end

    assign resp_valid = resp_valid_ff;
    assign resp_rdata = resp_rdata_ff;

    // ----------------------------------------
    // Pin drivers, registered from the next state
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_hi_ff      <= 8'h00;
            addr_hi_oe_n_ff <= 1'b1;
            addr_lo_ff      <= 8'h00;
        end else if (start && ext_en) begin
            // Undriven upper byte lets software own those port lines
            addr_hi_ff      <= eff_addr[15:8];
            addr_hi_oe_n_ff <= ~drive_hi;
            addr_lo_ff      <= eff_addr[7:0];
        end else if (nxt_state == EMST_IDLE) begin
            addr_hi_oe_n_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_ff      <= 8'h00;
            data_oe_n_ff <= 1'b1;
        end else begin
            case (nxt_state)
                EMST_ALE_HI, EMST_ALE_LO: begin
                    data_ff      <= start ? eff_addr[7:0]
                                          : acc_addr_ff[7:0];
                    data_oe_n_ff <= 1'b0;
                end
                EMST_SETUP, EMST_STROBE, EMST_HOLD: begin
                    data_ff      <= start ? req_wdata : acc_wdata_ff;
                    data_oe_n_ff <= start ? ~req_write
                                          : ~acc_write_ff;
                end
                default: begin
                    data_oe_n_ff <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ale_ff  <= 1'b0;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
        end else begin
            ale_ff  <= (nxt_state == EMST_ALE_HI);
            rd_n_ff <= ~((nxt_state == EMST_STROBE) &
                        ~(start ? req_write : acc_write_ff));
            wr_n_ff <= ~((nxt_state == EMST_STROBE) &
                         (start ? req_write : acc_write_ff));
        end
    end

    assign addr_hi_o    = addr_hi_ff;
    assign addr_hi_oe_n = addr_hi_oe_n_ff;
    assign addr_lo_o    = addr_lo_ff;
    assign data_o       = data_ff;
    assign data_oe_n    = data_oe_n_ff;
    assign ale_o        = ale_ff;
    assign rd_n_o       = rd_n_ff;
    assign wr_n_o       = wr_n_ff;

endmodule : emst_ctrl

//--- verif/emst_ctrl_properties.sv
`timescale 1ns/1ps
module emst_checker
    import emst_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_wide,
    input wire logic [7:0]  req_wdata,
    input wire logic        resp_valid,
    input wire logic [7:0]  addr_hi_o,
    input wire logic        addr_hi_oe_n,
    input wire logic [7:0]  addr_lo_o,
    input wire logic [7:0]  data_o,
    input wire logic        data_oe_n,
    input wire logic        ale_o,
    input wire logic        rd_n_o,
    input wire logic        wr_n_o
);
    logic [7:0] tmg_ff, cfg_ff, wd_ff, ph_ff, pre, tot;
    logic [4:0] sb_ff, al_ff, alen;
    logic       wide_ff, strb;
    // ----------------------------------------
    // Shadow registers and phase counters
    // ----------------------------------------
    assign strb = !rd_n_o || !wr_n_o;
    assign alen = cfg_ff[4] ? 5'h00 : 5'h01 + {3'h0, cfg_ff[1:0]};
    assign pre = {2'h0, alen, 1'b0} + {6'h0, tmg_ff[7:6]};
    assign tot = (cfg_ff[3:2] == 2'h0) ? 8'h00 : pre + {4'h0, tmg_ff[5:2]}
                 + {6'h0, tmg_ff[1:0]} + 8'h05;
    always_ff @(posedge clk) begin
        if (rst) begin
            tmg_ff <= EMST_RST_TIMING;
            cfg_ff <= EMST_RST_CONFIG;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == EMST_OFS_TIMING) tmg_ff <= avs_writedata[7:0];
            if (avs_address == EMST_OFS_CONFIG) cfg_ff <= avs_writedata[7:0];
        end
    end
    // Saturates so a long idle stretch never wraps into a false match
    always_ff @(posedge clk) begin
        if (rst || (req_valid && req_ready)) ph_ff <= 8'h00;
        else if (ph_ff != 8'hff) ph_ff <= ph_ff + 8'h01;
    end
    always_ff @(posedge clk) begin
        sb_ff <= (strb && !rst) ? sb_ff + 5'h01 : 5'h00;
        al_ff <= (ale_o && !rst) ? al_ff + 5'h01 : 5'h00;
        if (req_valid && req_ready) wide_ff <= req_wide;
        if (req_valid && req_ready) wd_ff <= req_wdata;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_setup; $rose(strb) |-> ph_ff == pre; endproperty
    a_setup: assert property (p_setup)
        else $error("strobe start cycle wrong");
    property p_width; $fell(strb) |-> sb_ff == tmg_ff[5:2] + 5'h01; endproperty
    a_width: assert property (p_width)
        else $error("strobe width wrong");
    property p_total; resp_valid |-> ph_ff == tot; endproperty
    a_total: assert property (p_total)
        else $error("move length wrong");
    property p_keep;
        !req_ready && !$past(req_ready) |-> $stable({addr_hi_o, addr_lo_o});
    endproperty
    a_keep: assert property (p_keep)
        else $error("address moved during access");
    property p_ale_w; $fell(ale_o) |-> al_ff == alen; endproperty
    a_ale_w: assert property (p_ale_w)
        else $error("latch pulse width wrong");
    property p_no_ale; ale_o |-> !cfg_ff[4] && cfg_ff[3:2] != 2'h0; endproperty
    a_no_ale: assert property (p_no_ale)
        else $error("latch pulse in non-multiplexed mode");
    property p_hi_drv;
        $rose(strb) |-> addr_hi_oe_n == !(wide_ff || cfg_ff[3:2] == 2'h2);
    endproperty
    a_hi_drv: assert property (p_hi_drv)
        else $error("upper address drive wrong");
    property p_ad_addr; ale_o |-> !data_oe_n && data_o == addr_lo_o; endproperty
    a_ad_addr: assert property (p_ad_addr)
        else $error("shared bus not showing address");
    property p_wr_data; !wr_n_o |-> !data_oe_n && data_o == wd_ff; endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write data wrong");
endmodule : emst_checker

bind emst_ctrl emst_checker u_chk (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .req_valid(req_valid), .req_ready(req_ready), .req_wide(req_wide),
    .req_wdata(req_wdata), .resp_valid(resp_valid), .addr_hi_o(addr_hi_o),
    .addr_hi_oe_n(addr_hi_oe_n), .addr_lo_o(addr_lo_o), .data_o(data_o),
    .data_oe_n(data_oe_n), .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));

//--- verif/emst_ext_mem.sv
`timescale 1ns/1ps
module emst_ext_mem (
    input wire logic        clk,
    input wire logic        muxed,
    input wire logic        slow,
    input wire logic [7:0]  addr_hi_o,
    input wire logic        addr_hi_oe_n,
    input wire logic [7:0]  addr_lo_o,
    input wire logic [7:0]  data_o,
    input wire logic        ale_o,
    input wire logic        rd_n_o,
    input wire logic        wr_n_o,
    output logic [7:0]      data_i,
    output logic [15:0]     last_addr
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  latch_q, alt_q = 8'h5a, rd_q;
    logic [15:0] ea;
    logic        rd_seen;
    // Undriven upper address pins float to the pull-up level
    assign ea = {addr_hi_oe_n ? 8'hff : addr_hi_o, muxed ? latch_q : addr_lo_o};
    assign rd_q = mem[ea];
    // Slow part shows data only from the second strobe cycle on
    assign data_i = (!rd_n_o && (!slow || rd_seen)) ? rd_q : alt_q;
    always @(posedge clk) begin
        alt_q <= ~alt_q;
        rd_seen <= !rd_n_o;
        if (ale_o) latch_q <= data_o;
        if (!wr_n_o) mem[ea] <= data_o;
        if (!rd_n_o || !wr_n_o) last_addr <= ea;
    end
endmodule : emst_ext_mem

//--- verif/test_ext_mem_strobe_timing.sv
`timescale 1ns/1ps
module test_ext_mem_strobe_timing;
    import emst_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00, rv, tmg, cfg, dd, hi;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        req_valid = 1'b0, req_write = 1'b0, req_wide = 1'b0;
    logic        req_ptr_sel = 1'b0, muxed = 1'b0, slow = 1'b0;
    logic [15:0] req_addr = 16'h0, last_addr, ea;
    logic [7:0]  req_wdata = 8'h00, resp_rdata, addr_hi_o, addr_lo_o;
    logic [7:0]  data_o, data_i;
    logic        avs_waitrequest, req_ready, resp_valid, addr_hi_oe_n;
    logic        data_oe_n, ale_o, rd_n_o, wr_n_o;
    logic [3:0]  k;
    int          err_count = 0, total_checks = 0, cyc = 0, nx;
    emst_ctrl dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_wide(req_wide),
        .req_ptr_sel(req_ptr_sel), .req_addr(req_addr),
        .req_wdata(req_wdata), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .addr_hi_o(addr_hi_o),
        .addr_hi_oe_n(addr_hi_oe_n), .addr_lo_o(addr_lo_o),
        .data_o(data_o), .data_i(data_i), .data_oe_n(data_oe_n),
        .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
    emst_ext_mem mem (.clk(clk), .muxed(muxed), .slow(slow),
        .addr_hi_o(addr_hi_o), .addr_hi_oe_n(addr_hi_oe_n),
        .addr_lo_o(addr_lo_o), .data_o(data_o), .ale_o(ale_o),
        .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .data_i(data_i),
        .last_addr(last_addr));
    // ----------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------
    initial begin
        forever #5 clk = ~clk;
    end
    // Whole run needs about 680 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // ----------------------------------------
    // Register bus and move port access
    // ----------------------------------------
    task automatic bus(logic wr, logic [7:0] a, logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic move(logic wr, logic wd, logic [15:0] a, logic [7:0] d,
                        logic [7:0] exp_rd);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_wide <= wd;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (resp_valid !== 1'b1);
        check("move cycles", nx, n);
        if (!wr) check("read data", exp_rd, resp_rdata);
        if (nx > 1) check("address", ea, last_addr);
    endtask : move
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, EMST_OFS_TIMING, 8'h00, rv);
        check("timing reset", 8'hff, rv);
        bus(1'b1, 8'h00, 8'h77, rv);
        bus(1'b0, 8'h00, 8'h00, rv);
        check("unmapped read", 8'h00, rv);
        bus(1'b1, EMST_OFS_TIMING, 8'h5a, rv);
        bus(1'b0, EMST_OFS_TIMING, 8'h00, rv);
        check("timing rw", 8'h5a, rv);
        bus(1'b1, EMST_OFS_PAGE, 8'hc6, rv);
        bus(1'b1, EMST_OFS_PTR0, 8'h3c, rv);
        bus(1'b1, EMST_OFS_PTR1, 8'hb1, rv);
        for (int m = 0; m < 8; m++) begin
            for (int w = 0; w < 2; w++) begin
                k = 4'(m * 2 + w);
                tmg = {k[1:0], k, k[2:1]};
                cfg = {3'h0, 3'(m), k[3:2]};
                muxed <= (m < 4);
                slow <= (k != 4'h0);
                req_ptr_sel <= m[0];
                bus(1'b1, EMST_OFS_TIMING, tmg, rv);
                bus(1'b1, EMST_OFS_CONFIG, cfg, rv);
                nx = tmg[7:6] + tmg[5:2] + tmg[1:0] + 6;
                if (m < 4) nx = nx + 2 * (cfg[1:0] + 1);
                if (m[1:0] == 0) nx = 1;
                hi = (m[1:0] == 2) ? 8'hc6 : 8'hff;
                ea = {hi, m[0] ? 8'hb1 : 8'h3c};
                if (w == 1) ea = {4'ha, k, 4'h3, k};
                dd = {k, 4'h9};
                move(1'b1, w[0], ea, dd, 8'h00);
                move(1'b0, w[0], ea, dd, (nx > 1) ? dd : 8'h00);
            end
        end
        bus(1'b0, EMST_OFS_STATUS, 8'h00, rv);
        check("status", dd, rv);
        print_verdict();
    end
endmodule : test_ext_mem_strobe_timing
